// file: rtl/cpe_engine.sv
// Purpose: Compare and PWM engine with its two timers, reached over Avalon-MM.
// Assumes: clk_sys is the oscillator; the instruction rate is one quarter of it.
// Notes: The pin is driven outside through a port mux using pin_own and pin_val.
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "cpe_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module cpe_engine
    import cpe_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [`CPE_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sleep_in,
    input wire logic adc_enable_in,
    output logic pin_val,
    output logic pin_own,
    output logic special_event,
    output logic adc_start
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic cpe_fn_e mode_fn(input logic [3:0] m);
        if (m[3:2] == 2'b11) begin
            return CPE_FN_PWM;
        end else if (m == `CPE_MODE_TOGGLE || m[3:2] == 2'b10) begin
            return CPE_FN_CMP;
        end else begin
            return CPE_FN_OFF;
        end
    endfunction

    function automatic logic drives_pin(input logic [3:0] m);
        return m == `CPE_MODE_SET || m == `CPE_MODE_CLEAR || m == `CPE_MODE_TOGGLE;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state.

    logic [3:0] mode_nibble_r;
    logic [1:0] duty_low_bits_r;
    logic [7:0] compare_low_duty_r;
    logic [7:0] compare_high_duty_r;
    logic [1:0] duty_latch_r;
    logic [15:0] first_timer_count_r;
    logic [2:0] t1ctl_r;
    logic [2:0] t1_pre_r;
    logic [7:0] second_timer_count_r;
    logic [7:0] period_r;
    logic [6:0] t2ctl_r;
    logic [3:0] t2_pre_r;
    logic [3:0] t2_post_r;
    logic [2:0] flags_r;
    logic [1:0] q_phase_r;
    logic cmp_latch_r;
    logic pwm_pin_r;
    logic match_prev_r;
    logic roll_d_r;
    logic sleep_m_r, sleep_r, adc_m_r, adc_r;
    logic waitreq_r;
    logic [31:0] rdata_r;
    logic pin_val_r, pin_own_r, special_r, adc_start_r;

    cpe_fn_e fn;
    logic req, take, wr_go;
    logic itick, t1_tick, t2_tick, t2_roll;
    logic [15:0] compare_value;
    logic match;
    logic match_rise;
    logic special_mode;
    logic [1:0] tb_low;
    logic [9:0] time_base;
    logic [9:0] duty_active;
    logic [3:0] t2_pre_last;
    logic [2:0] t1_mask;
    logic [2:0] flag_set, flag_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs pass two flip-flops.

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sleep_m_r <= 1'b0;
            sleep_r <= 1'b0;
            adc_m_r <= 1'b0;
            adc_r <= 1'b0;
        end else begin
            sleep_m_r <= sleep_in;
            sleep_r <= sleep_m_r;
            adc_m_r <= adc_enable_in;
            adc_r <= adc_m_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then the answer.

    assign req = avs_read | avs_write;
    assign take = req & ~waitreq_r;
    assign wr_go = take & avs_write;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            waitreq_r <= 1'b1;
        end else if (req & waitreq_r) begin
            waitreq_r <= 1'b0;
        end else begin
            waitreq_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_r <= 32'h0;
        end else if (avs_read & waitreq_r) begin
            case (avs_address)
                `CPE_OFS_CTRL: rdata_r <= {26'h0, duty_low_bits_r, mode_nibble_r};
                `CPE_OFS_CMPL: rdata_r <= {24'h0, compare_low_duty_r};
                `CPE_OFS_CMPH: rdata_r <= {24'h0, compare_high_duty_r};
                `CPE_OFS_T1CNT: rdata_r <= {16'h0, first_timer_count_r};
                `CPE_OFS_T1CTL: rdata_r <= {29'h0, t1ctl_r};
                `CPE_OFS_T2CNT: rdata_r <= {24'h0, second_timer_count_r};
                `CPE_OFS_PER: rdata_r <= {24'h0, period_r};
                `CPE_OFS_T2CTL: rdata_r <= {25'h0, t2ctl_r};
                `CPE_OFS_FLAGS: rdata_r <= {29'h0, flags_r};
                `CPE_OFS_STAT: rdata_r <= {28'h0, sleep_r, pwm_pin_r, cmp_latch_r, match};
                default: rdata_r <= 32'h0;
            endcase
        end
    end

    function automatic logic wr_at(input logic [`CPE_ADDR_W-1:0] ofs);
        return wr_go && avs_address == ofs && avs_byteenable[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Control and duty registers.

    assign fn = mode_fn(mode_nibble_r);
    assign special_mode = mode_nibble_r == `CPE_MODE_SPECIAL;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_nibble_r <= 4'h0;
            duty_low_bits_r <= 2'h0;
            compare_low_duty_r <= 8'h0;
            period_r <= `CPE_PER_RST;
            t1ctl_r <= 3'h0;
            t2ctl_r <= 7'h0;
        end else begin
            if (wr_at(`CPE_OFS_CTRL)) begin
                mode_nibble_r <= avs_writedata[3:0];
                duty_low_bits_r <= avs_writedata[5:4];
            end
            if (wr_at(`CPE_OFS_CMPL)) begin
                compare_low_duty_r <= avs_writedata[7:0];
            end
            if (wr_at(`CPE_OFS_PER)) begin
                period_r <= avs_writedata[7:0];
            end
            if (wr_at(`CPE_OFS_T1CTL)) begin
                t1ctl_r <= avs_writedata[2:0];
            end
            if (wr_at(`CPE_OFS_T2CTL)) begin
                t2ctl_r <= avs_writedata[6:0];
            end
        end
    end

    // Upper byte is the compare high byte, or the active duty byte in PWM.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            compare_high_duty_r <= 8'h0;
            duty_latch_r <= 2'h0;
        end else if (fn == CPE_FN_PWM && t2_roll) begin
            compare_high_duty_r <= compare_low_duty_r;
            duty_latch_r <= duty_low_bits_r;
        end else if (wr_at(`CPE_OFS_CMPH) && fn != CPE_FN_PWM) begin
            compare_high_duty_r <= avs_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction-rate divider; sleep stops every timer.

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q_phase_r <= 2'h0;
        end else if (!sleep_r) begin
            q_phase_r <= q_phase_r + 2'h1;
        end
    end

    assign itick = !sleep_r && q_phase_r == `CPE_INSTR_LAST;

    ////////////////////////////////////////////////////////////////////////////
    // First timer and compare.

    assign t1_mask = (3'h1 << t1ctl_r[2:1]) - 3'h1;
    assign t1_tick = itick && t1ctl_r[`CPE_T1CTL_ON] && (t1_pre_r & t1_mask) == t1_mask;
    assign compare_value = {compare_high_duty_r, compare_low_duty_r};
    assign match = fn == CPE_FN_CMP && first_timer_count_r == compare_value;
    assign match_rise = match & ~match_prev_r;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            t1_pre_r <= 3'h0;
            first_timer_count_r <= 16'h0;
        end else begin
            if (itick && t1ctl_r[`CPE_T1CTL_ON]) begin
                t1_pre_r <= t1_pre_r + 3'h1;
            end
            if (wr_go && avs_address == `CPE_OFS_T1CNT) begin
                if (avs_byteenable[0]) begin
                    first_timer_count_r[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    first_timer_count_r[15:8] <= avs_writedata[15:8];
                end
            end else if (t1_tick) begin
                if (special_mode && match) begin
                    first_timer_count_r <= 16'h0;
                end else begin
                    first_timer_count_r <= first_timer_count_r + 16'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            match_prev_r <= 1'b0;
        end else begin
            match_prev_r <= match;
        end
    end

    // Acting on the rising edge keeps a toggle from repeating while equal.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmp_latch_r <= 1'b0;
        end else if (mode_nibble_r == `CPE_MODE_OFF) begin
            cmp_latch_r <= 1'b0;
        end else if (match_rise) begin
            case (mode_nibble_r)
                `CPE_MODE_SET: cmp_latch_r <= 1'b1;
                `CPE_MODE_CLEAR: cmp_latch_r <= 1'b0;
                `CPE_MODE_TOGGLE: cmp_latch_r <= ~cmp_latch_r;
                default: cmp_latch_r <= cmp_latch_r;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            special_r <= 1'b0;
            adc_start_r <= 1'b0;
        end else begin
            special_r <= special_mode && match_rise;
            adc_start_r <= special_mode && match_rise && adc_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Second timer and PWM.

    assign t2_pre_last = t2ctl_r[1:0] == `CPE_PS_1 ? 4'h0 :
                         t2ctl_r[1:0] == `CPE_PS_4 ? `CPE_PS4_LAST : `CPE_PS16_LAST;
    assign t2_tick = itick && t2ctl_r[`CPE_T2CTL_ON] && t2_pre_r == t2_pre_last;
    assign t2_roll = t2_tick && second_timer_count_r == period_r;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            t2_pre_r <= 4'h0;
            second_timer_count_r <= 8'h0;
        end else if (wr_at(`CPE_OFS_T2CNT)) begin
            t2_pre_r <= 4'h0;
            second_timer_count_r <= avs_writedata[7:0];
        end else if (itick && t2ctl_r[`CPE_T2CTL_ON]) begin
            t2_pre_r <= t2_tick ? 4'h0 : t2_pre_r + 4'h1;
            if (t2_roll) begin
                second_timer_count_r <= 8'h0;
            end else if (t2_tick) begin
                second_timer_count_r <= second_timer_count_r + 8'h1;
            end
        end
    end

    // Postscaler only paces the second timer's flag, never the period.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            t2_post_r <= 4'h0;
        end else if (t2_roll) begin
            t2_post_r <= t2_post_r == t2ctl_r[6:3] ? 4'h0 : t2_post_r + 4'h1;
        end
    end

    assign tb_low = t2ctl_r[1:0] == `CPE_PS_1 ? q_phase_r :
                    t2ctl_r[1:0] == `CPE_PS_4 ? t2_pre_r[1:0] : t2_pre_r[3:2];
    assign time_base = {second_timer_count_r, tb_low};
    assign duty_active = {compare_high_duty_r, duty_latch_r};

    // Set one cycle after rollover, so set and clear both see the time base one cycle late.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            roll_d_r <= 1'b0;
        end else if (!sleep_r) begin
            roll_d_r <= t2_roll;
        end
    end

    // A duty above the period never matches, so the pin stays high after each rollover sets it.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || fn != CPE_FN_PWM) begin
            pwm_pin_r <= 1'b0;
        end else if (sleep_r) begin
            pwm_pin_r <= pwm_pin_r;
        end else if (roll_d_r) begin
            pwm_pin_r <= duty_active != 10'h0;
        end else if (time_base == duty_active) begin
            pwm_pin_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags: write one to clear; a set in the same cycle wins.

    assign flag_set[`CPE_FLG_UNIT] = match_rise;
    assign flag_set[`CPE_FLG_T1OVF] = t1_tick && !(special_mode && match) &&
                                      first_timer_count_r == 16'hffff;
    assign flag_set[`CPE_FLG_T2] = t2_roll && t2_post_r == t2ctl_r[6:3];
    assign flag_clr = wr_at(`CPE_OFS_FLAGS) ? avs_writedata[2:0] : 3'h0;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_r <= 3'h0;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin ownership and level.

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_own_r <= 1'b0;
            pin_val_r <= 1'b0;
        end else if (fn == CPE_FN_PWM) begin
            pin_own_r <= 1'b1;
            pin_val_r <= pwm_pin_r;
        end else begin
            pin_own_r <= drives_pin(mode_nibble_r);
            pin_val_r <= cmp_latch_r;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = waitreq_r;
    assign pin_val = pin_val_r;
    assign pin_own = pin_own_r;
    assign special_event = special_r;
    assign adc_start = adc_start_r;

endmodule // cpe_engine

// file: common/cpe_consts.svh
// Purpose: Offsets, field positions, reset values and counts for the compare and PWM engine.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef CPE_CONSTS_SVH
`define CPE_CONSTS_SVH

`define CPE_ADDR_W 6
`define CPE_OFS_CTRL 6'h00
`define CPE_OFS_CMPL 6'h04
`define CPE_OFS_CMPH 6'h08
`define CPE_OFS_T1CNT 6'h0c
`define CPE_OFS_T1CTL 6'h10
`define CPE_OFS_T2CNT 6'h14
`define CPE_OFS_PER 6'h18
`define CPE_OFS_T2CTL 6'h1c
`define CPE_OFS_FLAGS 6'h20
`define CPE_OFS_STAT 6'h24

`define CPE_MODE_OFF 4'h0
`define CPE_MODE_TOGGLE 4'h2
`define CPE_MODE_SET 4'h8
`define CPE_MODE_CLEAR 4'h9
`define CPE_MODE_SOFTINT 4'ha
`define CPE_MODE_SPECIAL 4'hb

`define CPE_FLG_UNIT 0
`define CPE_FLG_T1OVF 1
`define CPE_FLG_T2 2
`define CPE_T1CTL_ON 0
`define CPE_T2CTL_ON 2
`define CPE_INSTR_LAST 2'h3
`define CPE_PER_RST 8'hff
`define CPE_PS_1 2'h0
`define CPE_PS_4 2'h1
`define CPE_PS4_LAST 4'h3
`define CPE_PS16_LAST 4'hf

`endif

// file: common/cpe_pkg.sv
// Purpose: Types shared by the compare and PWM engine.
// Assumes: Constants live in cpe_consts.svh.
// Notes: The unit function is decoded from the mode nibble.
package cpe_pkg;
    typedef enum logic [2:0] {
        CPE_FN_OFF = 3'b001,
        CPE_FN_CMP = 3'b010,
        CPE_FN_PWM = 3'b100
    } cpe_fn_e;
endpackage

// file: verification/cpe_sva.sv
// Purpose: Port checks for the compare and PWM engine.
// Assumes: Bound to cpe_engine.
// Notes: Sleep and enable pass a two-flop sync, hence the longer holds.
`timescale 1ns/1ps
`include "cpe_consts.svh"
module cpe_sva (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [`CPE_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic sleep_in,
    input wire logic adc_enable_in,
    input wire logic pin_val,
    input wire logic pin_own,
    input wire logic special_event,
    input wire logic adc_start
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer late");
    property p_wait_stand; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_stand: assert property (p_wait_stand) else $error("bus answer held");
    property p_evt_pulse; special_event |=> !special_event; endproperty
    a_evt_pulse: assert property (p_evt_pulse) else $error("event too long");
    property p_evt_pin; special_event |-> !pin_own; endproperty
    a_evt_pin: assert property (p_evt_pin) else $error("event mode owns pin");
    property p_adc_gate; adc_start |-> special_event; endproperty
    a_adc_gate: assert property (p_adc_gate) else $error("stray converter start");
    property p_adc_on; adc_enable_in [*4] ##0 special_event |-> adc_start; endproperty
    a_adc_on: assert property (p_adc_on) else $error("converter start missing");
    property p_pwm_release;
        avs_write && !avs_waitrequest && avs_address == `CPE_OFS_CTRL && avs_byteenable[0]
            && avs_writedata[3:0] == 4'h0 |-> ##[1:3] !pin_own;
    endproperty
    a_pwm_release: assert property (p_pwm_release) else $error("pin not released");
    property p_sleep_hold; sleep_in [*5] |=> $stable(pin_val) && $stable(pin_own); endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("pin moved in sleep");
endmodule // cpe_sva
bind cpe_engine cpe_sva u_cpe_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .sleep_in(sleep_in),
    .adc_enable_in(adc_enable_in), .pin_val(pin_val), .pin_own(pin_own),
    .special_event(special_event), .adc_start(adc_start));

// file: verification/cpe_load.sv
// Purpose: Load on the unit pin; measures pulse and period lengths.
// Assumes: Pad pulls low while the port driver is off.
// Notes: Lengths are in clk_sys cycles.
`timescale 1ns/1ps
module cpe_load (
    input wire logic clk_sys,
    input wire logic pin_direction_bit,
    input wire logic pin_own,
    input wire logic pin_val,
    input wire logic port_val,
    output logic level,
    output int last_high,
    output int last_per,
    output int still
);
    int hi_run = 0;
    int per_run = 0;
    logic prev = 1'b0;
    assign level = pin_direction_bit ? 1'b0 : (pin_own ? pin_val : port_val);
    always @(posedge clk_sys) begin
        still <= (level != prev) ? 1 : still + 1;
        if (level && !prev) begin
            last_per <= per_run;
            per_run <= 1;
            hi_run <= 1;
        end else begin
            per_run <= per_run + 1;
            hi_run <= hi_run + int'(level);
        end
        if (!level && prev) begin
            last_high <= hi_run;
        end
        prev <= level;
    end
endmodule // cpe_load

// file: verification/tb.sv
// Purpose: Self-checking bench for the compare and PWM engine.
// Assumes: One bus request at a time; read notes queue in order.
// Notes: Pin timing comes from the load model.
`timescale 1ns/1ps
`include "cpe_consts.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
$display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb;
    logic clk_sys = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic sleep_in = 1'b0, adc_enable_in = 1'b0, port_data = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rnd = 32'd88197;
    logic avs_waitrequest, pin_val, pin_own, special_event, adc_start, lvl, lv;
    logic [63:0] note_q[$], note;
    logic [15:0] cmp;
    logic [9:0] d;
    int last_high, last_per, still, per, evt_n = 0, adc_n = 0, cyc = 0, check_count = 0, miscompares = 0;
    logic [3:0] mode_t[6] = '{4'h9, 4'h8, 4'h2, 4'h2, 4'h8, 4'ha};
    logic [5:0] latch_t = 6'b111010, own_t = 6'b011111;
    logic [7:0] p_t[6] = '{8'h07, 8'h07, 8'hff, 8'h07, 8'h07, 8'h07};
    logic [1:0] ps_t[6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
    int psv_t[6] = '{1, 1, 1, 4, 16, 1};
    logic [9:0] d_t[6] = '{10'h000, 10'h028, 10'h3ff, 10'h005, 10'h003, 10'h000};
    cpe_engine u_cpe_engine (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_in(sleep_in),
        .adc_enable_in(adc_enable_in), .pin_val(pin_val), .pin_own(pin_own),
        .special_event(special_event), .adc_start(adc_start));
    cpe_load u_cpe_load (.clk_sys(clk_sys), .pin_direction_bit(1'b0), .pin_own(pin_own), .pin_val(pin_val),
        .port_val(port_data), .level(lvl), .last_high(last_high), .last_per(last_per), .still(still));
    always #4 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= v;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        note_q.push_back({m, e});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cyc++;
        if (special_event) evt_n++;
        if (adc_start) adc_n++;
        if (avs_read && !avs_waitrequest) begin
            note = note_q.pop_front();
            `CHK(avs_readdata & note[63:32], note[31:0])
        end
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(`CPE_OFS_PER, 32'hff, 32'hff);
        rd(`CPE_OFS_CTRL, 32'h3f, 32'h0);
        wr(6'h3c, 32'h5a);
        rd(6'h3c, 32'hffffffff, 32'h0);
        wr(`CPE_OFS_T1CTL, 32'h1);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            cmp = 16'h10 + 16'(rnd[4:0]);
            port_data <= ~latch_t[i];
            rnd = lfsr(rnd);
            wr(`CPE_OFS_T1CNT, 32'h0);
            wr(`CPE_OFS_CMPL, 32'(cmp[7:0]));
            wr(`CPE_OFS_CMPH, 32'(cmp[15:8]));
            wr(`CPE_OFS_CTRL, 32'(mode_t[i]));
            repeat ((cmp + 8) * 4) @(posedge clk_sys);
            rd(`CPE_OFS_FLAGS, 32'h3, 32'h1);
            wr(`CPE_OFS_FLAGS, 32'h1);
            rd(`CPE_OFS_STAT, 32'h2, {30'h0, latch_t[i], 1'b0});
            `CHK(lvl, own_t[i] ? latch_t[i] : port_data)
        end
        wr(`CPE_OFS_CTRL, 32'h0);
        rd(`CPE_OFS_STAT, 32'h2, 32'h0);
        $display("test compare done");
        adc_enable_in <= 1'b1;
        cmp = 16'h20 + 16'(rnd[3:0]);
        wr(`CPE_OFS_T1CNT, 32'h0);
        wr(`CPE_OFS_CMPL, 32'(cmp[7:0]));
        wr(`CPE_OFS_CMPH, 32'h0);
        evt_n = 0;
        adc_n = 0;
        wr(`CPE_OFS_CTRL, 32'hb);
        repeat ((cmp + 1) * 14) @(posedge clk_sys);
        `CHK(evt_n, 3)
        `CHK(adc_n, 3)
        wr(`CPE_OFS_T1CNT, 32'hfff0);
        wr(`CPE_OFS_CMPL, 32'hff);
        wr(`CPE_OFS_CMPH, 32'hff);
        repeat (80) @(posedge clk_sys);
        `CHK(evt_n, 4)
        rd(`CPE_OFS_FLAGS, 32'h3, 32'h1);
        wr(`CPE_OFS_CTRL, 32'h0);
        wr(`CPE_OFS_FLAGS, 32'h7);
        $display("test special event done");
        for (int i = 0; i < 6; i++) begin
            d = (i == 5) ? 10'(1 + rnd[4:0]) : d_t[i];
            per = 4 * (p_t[i] + 1) * psv_t[i];
            wr(`CPE_OFS_PER, 32'(p_t[i]));
            wr(`CPE_OFS_T2CTL, {25'h0, 4'h5, 1'b1, ps_t[i]});
            wr(`CPE_OFS_T2CNT, 32'h0);
            wr(`CPE_OFS_CMPL, 32'(d[9:2]));
            wr(`CPE_OFS_CTRL, {26'h0, d[1:0], 4'hc});
            repeat (per * 3) @(posedge clk_sys);
            rd(`CPE_OFS_CMPH, 32'hff, 32'(d[9:2]));
            wr(`CPE_OFS_CMPH, 32'h5a);
            rd(`CPE_OFS_CMPH, 32'hff, 32'(d[9:2]));
            `CHK(pin_own, 1'b1)
            if (d == 0 || d > 4 * (p_t[i] + 1)) begin
                `CHK(lvl, d != 0)
                `CHK(still > per, 1'b1)
            end else begin
                `CHK(last_high, d * psv_t[i])
                `CHK(last_per, per)
            end
        end
        sleep_in <= 1'b1;
        repeat (8) @(posedge clk_sys);
        lv = lvl;
        wr(`CPE_OFS_CMPL, 32'h2);
        wr(`CPE_OFS_CTRL, 32'hc);
        repeat (per) @(posedge clk_sys);
        rd(`CPE_OFS_CMPH, 32'hff, 32'(d[9:2]));
        `CHK(lvl, lv)
        sleep_in <= 1'b0;
        repeat (per * 3) @(posedge clk_sys);
        `CHK(last_high, 8)
        wr(`CPE_OFS_CTRL, 32'h0);
        repeat (3) @(posedge clk_sys);
        `CHK(pin_own, 1'b0)
        $display("test pwm done");
        complete_run();
    end
endmodule // tb
